/* File: hdl/dac_core_delay_config_regs.sv */
`timescale 1ns/10ps
module dac_core_delay_config_regs (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire dac_cfg_pkg::reg_req_t i_req,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  input wire logic i_delay_loop_enable,
  input wire logic i_lock_value_capture,
  input wire logic i_slope_positive,
  input wire dac_cfg_pkg::lock_sample_t i_live_lock,
  input wire logic i_phase_measured,
  input wire logic i_measured_slope_positive,
  output logic o_dac_power_down,
  output dac_cfg_pkg::rolloff_t o_rolloff,
  output dac_cfg_pkg::decoder_mode_t o_decoder_mode,
  output logic o_decoder_mode_invalid,
  output logic [8:0] o_search_start,
  output dac_cfg_pkg::sweep_t o_sweep_heading,
  output logic [4:0] o_target_phase,
  output logic o_target_phase_lockable,
  output logic o_lock_accept,
  output logic o_auto_mode,
  output logic [9:0] o_full_scale_current_code
);
  logic power_down_r;
  logic [1:0] msel_r;
  logic [1:0] dec_mode_r;
  logic [8:0] delay_r;
  logic [1:0] sweep_r;
  logic [4:0] phase_r;
  logic [9:0] fsc_r;
  logic [7:0] rdata_r;
  logic rvalid_r;
  logic out_pd_r;
  dac_cfg_pkg::rolloff_t out_rolloff_r;
  dac_cfg_pkg::decoder_mode_t out_dec_r;
  logic out_dec_inv_r;
  logic [8:0] out_start_r;
  dac_cfg_pkg::sweep_t out_sweep_r;
  logic [4:0] out_phase_r;
  logic out_lockable_r;
  logic lock_accept_r;
  logic auto_r;
  logic [9:0] out_fsc_r;
  dac_cfg_pkg::lock_sample_t sample;

  lock_value_sampler u_sampler (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_capture_level(i_lock_value_capture),
    .i_live(i_live_lock),
    .o_sample(sample),
    .o_captured()
  );

  wire wr_bias = i_req.wr && (i_req.addr == dac_cfg_pkg::ADDR_BIAS);
  wire wr_dec = i_req.wr && (i_req.addr == dac_cfg_pkg::ADDR_DECODER);
  wire wr_dly3 = i_req.wr && (i_req.addr == dac_cfg_pkg::ADDR_DELAY3);
  wire wr_dly4 = i_req.wr && (i_req.addr == dac_cfg_pkg::ADDR_DELAY4);
  wire wr_fsc_lo = i_req.wr && (i_req.addr == dac_cfg_pkg::ADDR_FSC_LOW);
  wire wr_fsc_hi = i_req.wr && (i_req.addr == dac_cfg_pkg::ADDR_FSC_HIGH);
  // Delay bits are locked out while the loop runs so software cannot fight the tracker
  wire manual = !i_delay_loop_enable;
  wire [8:0] delay_nxt = {wr_dly4 && manual ? i_req.wdata : delay_r[8:1],
    wr_dly3 && manual ? i_req.wdata[dac_cfg_pkg::POS_DELAY_LSB] : delay_r[0]};
  wire [8:0] delay_view = manual ? delay_r : sample.delay;
  wire [4:0] phase_view = manual ? phase_r : sample.phase;

  wire [7:0] rd_bias = {power_down_r, 5'h00, msel_r};
  wire [7:0] rd_dec = {6'h00, dec_mode_r};
  wire [7:0] rd_dly3 = {delay_view[0], sweep_r, phase_view};
  wire [7:0] rd_dly4 = delay_view[8:1];
  wire [7:0] rd_fsc_hi = {6'h00, fsc_r[9:8]};
  wire [7:0] rd_mux =
    (i_req.addr == dac_cfg_pkg::ADDR_BIAS) ? rd_bias :
    (i_req.addr == dac_cfg_pkg::ADDR_DECODER) ? rd_dec :
    (i_req.addr == dac_cfg_pkg::ADDR_DELAY3) ? rd_dly3 :
    (i_req.addr == dac_cfg_pkg::ADDR_DELAY4) ? rd_dly4 :
    (i_req.addr == dac_cfg_pkg::ADDR_FSC_LOW) ? fsc_r[7:0] :
    (i_req.addr == dac_cfg_pkg::ADDR_FSC_HIGH) ? rd_fsc_hi : 8'h00;

  wire dac_cfg_pkg::rolloff_t rolloff_dec =
    (msel_r == 2'h0) ? dac_cfg_pkg::ROLLOFF_BYPASS :
    (msel_r == 2'h1) ? dac_cfg_pkg::ROLLOFF_NARROW :
    (msel_r == 2'h2) ? dac_cfg_pkg::ROLLOFF_MEDIUM : dac_cfg_pkg::ROLLOFF_WIDE;
  wire dac_cfg_pkg::decoder_mode_t dec_dec =
    (dec_mode_r == 2'h0) ? dac_cfg_pkg::DEC_NORMAL :
    (dec_mode_r == 2'h1) ? dac_cfg_pkg::DEC_RTZ :
    (dec_mode_r == 2'h2) ? dac_cfg_pkg::DEC_MIX : dac_cfg_pkg::DEC_INVALID;
  wire dac_cfg_pkg::sweep_t sweep_dec =
    (sweep_r == 2'h0) ? dac_cfg_pkg::SWEEP_DOWN :
    (sweep_r == 2'h1) ? dac_cfg_pkg::SWEEP_UP :
    (sweep_r == 2'h2) ? dac_cfg_pkg::SWEEP_BOTH : dac_cfg_pkg::SWEEP_INVALID;
  wire lock_ok = i_phase_measured && (i_measured_slope_positive == i_slope_positive);

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      power_down_r <= dac_cfg_pkg::RST_POWER_DOWN;
      msel_r <= dac_cfg_pkg::RST_MSEL;
      dec_mode_r <= dac_cfg_pkg::RST_DEC_MODE;
      delay_r <= dac_cfg_pkg::RST_DELAY;
      sweep_r <= dac_cfg_pkg::RST_SWEEP;
      phase_r <= dac_cfg_pkg::RST_PHASE;
      fsc_r <= dac_cfg_pkg::RST_FSC;
    end else begin
      if (wr_bias) begin
        power_down_r <= i_req.wdata[dac_cfg_pkg::POS_POWER_DOWN];
        msel_r <= i_req.wdata[dac_cfg_pkg::POS_MSEL +: 2];
      end
      if (wr_dec) begin
        dec_mode_r <= i_req.wdata[dac_cfg_pkg::POS_DEC_MODE +: 2];
      end
      if (wr_dly3) begin
        sweep_r <= i_req.wdata[dac_cfg_pkg::POS_SWEEP +: 2];
        phase_r <= i_req.wdata[dac_cfg_pkg::POS_PHASE +: 5];
      end
      delay_r <= delay_nxt;
      if (wr_fsc_lo) begin
        fsc_r[7:0] <= i_req.wdata;
      end
      if (wr_fsc_hi) begin
        fsc_r[9:8] <= i_req.wdata[dac_cfg_pkg::POS_FSC_HIGH +: 2];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'h0;
    end else begin
      rvalid_r <= i_req.rd;
      rdata_r <= i_req.rd ? rd_mux : 8'h00;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      out_pd_r <= dac_cfg_pkg::RST_POWER_DOWN;
      out_rolloff_r <= dac_cfg_pkg::ROLLOFF_BYPASS;
      out_dec_r <= dac_cfg_pkg::DEC_NORMAL;
      out_dec_inv_r <= 1'h0;
      out_start_r <= dac_cfg_pkg::RST_DELAY;
      out_sweep_r <= dac_cfg_pkg::SWEEP_BOTH;
      out_phase_r <= dac_cfg_pkg::RST_PHASE;
      out_lockable_r <= 1'h1;
      lock_accept_r <= 1'h0;
      auto_r <= 1'h0;
      out_fsc_r <= dac_cfg_pkg::RST_FSC;
    end else begin
      out_pd_r <= power_down_r;
      out_rolloff_r <= rolloff_dec;
      out_dec_r <= dec_dec;
      out_dec_inv_r <= (dec_dec == dac_cfg_pkg::DEC_INVALID);
      out_start_r <= delay_r;
      out_sweep_r <= sweep_dec;
      out_phase_r <= phase_r;
      out_lockable_r <= (phase_r <= dac_cfg_pkg::PHASE_MAX);
      lock_accept_r <= lock_ok && out_lockable_r && auto_r;
      auto_r <= i_delay_loop_enable;
      out_fsc_r <= fsc_r;
    end
  end

  assign o_rdata = rdata_r;
  assign o_rvalid = rvalid_r;
  assign o_dac_power_down = out_pd_r;
  assign o_rolloff = out_rolloff_r;
  assign o_decoder_mode = out_dec_r;
  assign o_decoder_mode_invalid = out_dec_inv_r;
  assign o_search_start = out_start_r;
  assign o_sweep_heading = out_sweep_r;
  assign o_target_phase = out_phase_r;
  assign o_target_phase_lockable = out_lockable_r;
  assign o_lock_accept = lock_accept_r;
  assign o_auto_mode = auto_r;
  assign o_full_scale_current_code = out_fsc_r;

  AST_POWER_DOWN: assert property (@(posedge i_clk) disable iff (i_reset)
    wr_bias |-> ##2 (o_dac_power_down == $past(i_req.wdata[7], 2)))
    else $error("Power-down output does not follow written bit");
  AST_ROLLOFF: assert property (@(posedge i_clk) disable iff (i_reset)
    wr_bias |-> ##2 (o_rolloff == dac_cfg_pkg::rolloff_t'($past(i_req.wdata[1:0], 2))))
    else $error("Roll-off decode wrong");
  AST_DECODER_INVALID: assert property (@(posedge i_clk) disable iff (i_reset)
    (wr_dec && i_req.wdata[1:0] == 2'h3) |-> ##2 o_decoder_mode_invalid)
    else $error("Invalid decoder code not flagged");
  AST_DELAY_MANUAL_WRITE: assert property (@(posedge i_clk) disable iff (i_reset)
    (wr_dly4 && manual) |=> (delay_r[8:1] == $past(i_req.wdata)))
    else $error("Delay upper bits not written in manual mode");
  AST_DELAY_TRACK_LOCK: assert property (@(posedge i_clk) disable iff (i_reset)
    !manual |=> $stable(delay_r))
    else $error("Delay written while loop enabled");
  AST_READ_TRACKED: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_req.rd && i_req.addr == dac_cfg_pkg::ADDR_DELAY4 && !manual)
    |=> (o_rvalid && o_rdata == $past(sample.delay[8:1])))
    else $error("Tracking read does not return sampled delay");
  AST_RESERVED_ZERO: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_req.rd && i_req.addr == dac_cfg_pkg::ADDR_DECODER) |=> (o_rdata[7:2] == 6'h00))
    else $error("Reserved bits read non-zero");
  AST_PHASE_LOCKABLE: assert property (@(posedge i_clk) disable iff (i_reset)
    (phase_r > dac_cfg_pkg::PHASE_MAX) |=> !o_target_phase_lockable ##1 !o_lock_accept)
    else $error("Lock possible with phase above limit");
  AST_SLOPE_MISMATCH: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_phase_measured && i_measured_slope_positive != i_slope_positive) |=> !o_lock_accept)
    else $error("Lock accepted with wrong slope");
  AST_FSC_CODE: assert property (@(posedge i_clk) disable iff (i_reset)
    wr_fsc_hi |-> ##2 (o_full_scale_current_code[9:8] == $past(i_req.wdata[1:0], 2)))
    else $error("Full-scale code high bits wrong");

  COV_TRACK_READ: cover property (@(posedge i_clk) disable iff (i_reset)
    !manual && i_req.rd && i_req.addr == dac_cfg_pkg::ADDR_DELAY3);
  COV_LOCK: cover property (@(posedge i_clk) disable iff (i_reset) o_lock_accept);
  COV_MIX: cover property (@(posedge i_clk) disable iff (i_reset)
    o_decoder_mode == dac_cfg_pkg::DEC_MIX);
endmodule

/* File: hdl/dac_cfg_pkg.sv */
package dac_cfg_pkg;

  localparam logic [7:0] ADDR_BIAS = 8'h36;
  localparam logic [7:0] ADDR_DECODER = 8'h38;
  localparam logic [7:0] ADDR_DELAY3 = 8'h39;
  localparam logic [7:0] ADDR_DELAY4 = 8'h3a;
  localparam logic [7:0] ADDR_FSC_LOW = 8'h3c;
  localparam logic [7:0] ADDR_FSC_HIGH = 8'h3d;

  localparam int POS_POWER_DOWN = 7;
  localparam int POS_MSEL = 0;
  localparam int POS_DEC_MODE = 0;
  localparam int POS_DELAY_LSB = 7;
  localparam int POS_SWEEP = 5;
  localparam int POS_PHASE = 0;
  localparam int POS_FSC_HIGH = 0;

  localparam logic RST_POWER_DOWN = 1'h0;
  localparam logic [1:0] RST_MSEL = 2'h0;
  localparam logic [1:0] RST_DEC_MODE = 2'h0;
  localparam logic [8:0] RST_DELAY = 9'h0d8;
  localparam logic [1:0] RST_SWEEP = 2'h2;
  localparam logic [4:0] RST_PHASE = 5'h0e;
  localparam logic [9:0] RST_FSC = 10'h200;

  localparam logic [8:0] DELAY_MAX = 9'h1af;
  localparam logic [4:0] PHASE_MAX = 5'h10;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [8:0] delay;
    logic [4:0] phase;
  } lock_sample_t;

  typedef enum logic [1:0] {ROLLOFF_BYPASS, ROLLOFF_NARROW, ROLLOFF_MEDIUM, ROLLOFF_WIDE} rolloff_t;
  typedef enum logic [1:0] {DEC_NORMAL, DEC_RTZ, DEC_MIX, DEC_INVALID} decoder_mode_t;
  typedef enum logic [1:0] {SWEEP_DOWN, SWEEP_UP, SWEEP_BOTH, SWEEP_INVALID} sweep_t;

endpackage

/* File: hdl/lock_value_sampler.sv */
`timescale 1ns/10ps
module lock_value_sampler (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_capture_level,
  input wire dac_cfg_pkg::lock_sample_t i_live,
  output dac_cfg_pkg::lock_sample_t o_sample,
  output logic o_captured
);
  logic capture_prev_r;
  dac_cfg_pkg::lock_sample_t sample_r;
  logic captured_r;
  wire rise = i_capture_level && !capture_prev_r;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      capture_prev_r <= 1'h0;
      sample_r <= '0;
      captured_r <= 1'h0;
    end else begin
      capture_prev_r <= i_capture_level;
      captured_r <= rise;
      // Only the rising edge samples; holding the bit high freezes the value
      if (rise) begin
        sample_r <= i_live;
      end
    end
  end

  assign o_sample = sample_r;
  assign o_captured = captured_r;

  AST_CAPTURE_ON_RISE: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_capture_level && !capture_prev_r) |=> (o_sample == $past(i_live) && o_captured))
    else $error("Lock sample not taken on capture rise");
  AST_HOLD_WITHOUT_RISE: assert property (@(posedge i_clk) disable iff (i_reset)
    !(i_capture_level && !capture_prev_r) |=> $stable(o_sample) && !o_captured)
    else $error("Lock sample changed without capture rise");
  COV_CAPTURE: cover property (@(posedge i_clk) disable iff (i_reset) o_captured);
endmodule

/* File: test/tb.sv */
`timescale 1ns/10ps
module tb;
  logic i_clk;
  logic i_reset;
  dac_cfg_pkg::reg_req_t i_req;
  logic [7:0] o_rdata;
  logic o_rvalid;
  logic i_delay_loop_enable, i_lock_value_capture, i_slope_positive;
  dac_cfg_pkg::lock_sample_t i_live_lock, smp;
  logic i_phase_measured, i_measured_slope_positive;
  logic o_dac_power_down, o_decoder_mode_invalid, o_target_phase_lockable;
  logic o_lock_accept, o_auto_mode;
  dac_cfg_pkg::rolloff_t o_rolloff;
  dac_cfg_pkg::decoder_mode_t o_decoder_mode;
  dac_cfg_pkg::sweep_t o_sweep_heading;
  logic [8:0] o_search_start, dly;
  logic [4:0] o_target_phase, ph;
  logic [9:0] o_full_scale_current_code, full_scale_current_code;
  logic pd;
  logic [1:0] ms, dm, sw;
  logic [7:0] addrs [9] = '{8'h36, 8'h38, 8'h39, 8'h3a, 8'h3c, 8'h3d, 8'h37, 8'h3b, 8'h3e};
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;

  dac_core_delay_config_regs i_dac_core_delay_config_regs (.i_clk(i_clk), .i_reset(i_reset),
    .i_req(i_req), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
    .i_delay_loop_enable(i_delay_loop_enable), .i_lock_value_capture(i_lock_value_capture),
    .i_slope_positive(i_slope_positive), .i_live_lock(i_live_lock),
    .i_phase_measured(i_phase_measured), .i_measured_slope_positive(i_measured_slope_positive),
    .o_dac_power_down(o_dac_power_down), .o_rolloff(o_rolloff), .o_decoder_mode(o_decoder_mode),
    .o_decoder_mode_invalid(o_decoder_mode_invalid), .o_search_start(o_search_start),
    .o_sweep_heading(o_sweep_heading), .o_target_phase(o_target_phase),
    .o_target_phase_lockable(o_target_phase_lockable), .o_lock_accept(o_lock_accept),
    .o_auto_mode(o_auto_mode), .o_full_scale_current_code(o_full_scale_current_code));

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  task close_out;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Hang guard, well above the few hundred cycles the sequence needs
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      close_out;
    end
  end

  task chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      n_errors++;
    end
  endtask

  // Tracking mode shows the captured sample in both delay and phase fields
  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    logic [8:0] d;
    logic [4:0] p;
    d = i_delay_loop_enable ? smp.delay : dly;
    p = i_delay_loop_enable ? smp.phase : ph;
    case (a)
      dac_cfg_pkg::ADDR_BIAS: exp_rd = {pd, 5'h00, ms};
      dac_cfg_pkg::ADDR_DECODER: exp_rd = {6'h00, dm};
      dac_cfg_pkg::ADDR_DELAY3: exp_rd = {d[0], sw, p};
      dac_cfg_pkg::ADDR_DELAY4: exp_rd = d[8:1];
      dac_cfg_pkg::ADDR_FSC_LOW: exp_rd = full_scale_current_code[7:0];
      dac_cfg_pkg::ADDR_FSC_HIGH: exp_rd = {6'h00, full_scale_current_code[9:8]};
      default: exp_rd = 8'h00;
    endcase
  endfunction

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    #1 i_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_clk);
    #1 i_req = '0;
    case (a)
      8'h36: {pd, ms} = {d[7], d[1:0]};
      8'h38: dm = d[1:0];
      8'h39: {sw, ph} = d[6:0];
      8'h3c: full_scale_current_code[7:0] = d;
      8'h3d: full_scale_current_code[9:8] = d[1:0];
      default: ;
    endcase
    if (!i_delay_loop_enable && a == 8'h39) dly[0] = d[7];
    if (!i_delay_loop_enable && a == 8'h3a) dly[8:1] = d;
  endtask

  task rd(input logic [7:0] a);
    @(posedge i_clk);
    #1 i_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge i_clk);
    #1 i_req = '0;
    chk({15'h0, o_rvalid}, 16'h1);
    chk({8'h00, o_rdata}, {8'h00, exp_rd(a)});
  endtask

  task chk_out;
    repeat (2) @(posedge i_clk);
    #1;
    chk(o_dac_power_down, pd);
    chk(o_rolloff, ms);
    chk(o_decoder_mode, dm);
    chk(o_decoder_mode_invalid, dm == 2'h3);
    chk(o_search_start, dly);
    chk(o_sweep_heading, sw);
    chk(o_target_phase, ph);
    chk(o_target_phase_lockable, ph <= 5'h10);
    chk(o_full_scale_current_code, full_scale_current_code);
    chk(o_auto_mode, i_delay_loop_enable);
  endtask

  task lk(input logic m, input logic s, input logic e);
    int n;
    n = 0;
    @(posedge i_clk);
    #1 {i_slope_positive, i_measured_slope_positive, i_phase_measured} = {s, m, 1'b1};
    @(posedge i_clk);
    #1 i_phase_measured = 1'b0;
    repeat (3) begin
      if (o_lock_accept === 1'b1) n++;
      @(posedge i_clk);
      #1;
    end
    chk(16'(n), {15'h0, e});
  endtask

  task cap(input logic [8:0] d, input logic [4:0] p);
    @(posedge i_clk);
    #1 smp = '{delay: d, phase: p};
    i_live_lock = smp;
    @(posedge i_clk);
    #1 i_lock_value_capture = 1'b1;
    @(posedge i_clk);
    #1 i_live_lock = ~smp;
  endtask

  initial begin
    {i_reset, i_req, i_delay_loop_enable, i_lock_value_capture} = {1'b1, 18'h0, 2'b00};
    {i_slope_positive, i_phase_measured, i_measured_slope_positive} = 3'b000;
    i_live_lock = '0;
    void'($urandom(94));
    repeat (16) @(posedge i_clk);
    #1 i_reset = 1'b0;
    {pd, ms, dm, dly, sw, ph, full_scale_current_code} = {1'b0, 4'h0, 9'h0d8, 2'h2, 5'h0e, 10'h200};
    chk_out;
    foreach (addrs[k]) rd(addrs[k]);
    wr(8'h3a, 8'hd7);
    wr(8'h39, 8'hff);
    chk_out;
    wr(8'h3c, 8'hff);
    wr(8'h3d, 8'hff);
    chk_out;
    rd(8'h3d);
    wr(8'h3c, 8'h00);
    wr(8'h3d, 8'hfc);
    chk_out;
    for (int k = 0; k < 4; k++) begin
      wr(8'h36, {k[0], 5'h1f, k[1:0]});
      wr(8'h38, {6'h3f, k[1:0]});
      wr(8'h39, {1'b0, k[1:0], 5'h0e});
      chk_out;
    end
    repeat (40) begin
      automatic logic [7:0] a = addrs[$urandom_range(0, 8)];
      automatic logic [7:0] d = 8'($urandom);
      if (a == 8'h3a && d > 8'hd7) d = 8'hd7;
      wr(a, d);
      rd(a);
      chk_out;
    end
    @(posedge i_clk);
    #1 i_delay_loop_enable = 1'b1;
    cap(9'($urandom_range(0, 431)), 5'($urandom));
    rd(8'h39);
    rd(8'h3a);
    wr(8'h3a, 8'h12);
    wr(8'h39, 8'h80);
    chk_out;
    @(posedge i_clk);
    #1 i_lock_value_capture = 1'b0;
    cap(9'h1af, 5'h10);
    rd(8'h39);
    rd(8'h3a);
    wr(8'h39, 8'h4e);
    lk(1'b1, 1'b1, 1'b1);
    lk(1'b0, 1'b0, 1'b1);
    lk(1'b1, 1'b0, 1'b0);
    wr(8'h39, 8'h51);
    lk(1'b1, 1'b1, 1'b0);
    wr(8'h39, 8'h50);
    lk(1'b1, 1'b1, 1'b1);
    @(posedge i_clk);
    #1 i_delay_loop_enable = 1'b0;
    lk(1'b1, 1'b1, 1'b0);
    close_out;
  end
endmodule
